//--- verilog/long_imm_exec_pkg.sv
// Constants for the long-immediate ALU, stream get/put and byte-find unit.
// Assumes 32-bit instruction words with the major opcode in the top six bits.
package long_imm_exec_pkg;
  // Instruction field positions (LSB numbering)
  localparam int OPC_HI       = 31;
  localparam int OPC_LO       = 26;
  localparam int SUB_HI       = 20;
  localparam int SUB_LO       = 16;
  localparam int PUT_BIT      = 15;
  localparam int NONBLK_BIT   = 14;
  localparam int CTRL_BIT     = 13;
  localparam int CHAN_HI      = 3;
  localparam int CHAN_LO      = 0;
  localparam int IMM_HI       = 15;
  localparam int IMM_LO       = 0;
  localparam int FUNC_HI      = 10;
  localparam int FUNC_LO      = 0;
  // Major opcodes
  localparam logic [5:0]  OPC_LONG_IMM = 6'h1A;  // 011010
  localparam logic [5:0]  OPC_STREAM   = 6'h1B;  // 011011
  localparam logic [5:0]  OPC_OR_BF    = 6'h20;  // 100000
  localparam logic [10:0] FUNC_BYTE_FIND = 11'h400;
  // Sub-codes of the long-immediate group
  localparam logic [4:0] SUB_ADD      = 5'h00;
  localparam logic [4:0] SUB_RSUB     = 5'h01;
  localparam logic [4:0] SUB_ADDC     = 5'h02;
  localparam logic [4:0] SUB_RSUBC    = 5'h03;
  localparam logic [4:0] SUB_ADDK     = 5'h04;
  localparam logic [4:0] SUB_RSUBK    = 5'h05;
  localparam logic [4:0] SUB_ADDKC    = 5'h06;
  localparam logic [4:0] SUB_RSUBKC   = 5'h07;
  localparam logic [4:0] SUB_OR       = 5'h10;
  localparam logic [4:0] SUB_AND      = 5'h11;
  localparam logic [4:0] SUB_XOR      = 5'h12;
  localparam logic [4:0] SUB_ANDN     = 5'h13;
  // Register map
  localparam logic [7:0] ADDR_MSTATUS  = 8'h00;
  localparam logic [7:0] ADDR_INT_STAT = 8'h04;
  localparam logic [7:0] ADDR_INT_MASK = 8'h08;
  localparam int MST_CARRY_BIT = 0;
  localparam int MST_SERR_BIT  = 1;
  localparam int EV_DONE = 0;
  localparam int EV_SERR = 1;
  localparam int EV_MISS = 2;
  // Values after reset
  localparam logic [2:0] INT_MASK_RST = 3'h0;
  localparam logic       CARRY_RST    = 1'b0;
  localparam logic       SERR_RST     = 1'b0;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01
  } exec_state_t;
endpackage : long_imm_exec_pkg

//--- verilog/long_imm_exec.sv
// Execute unit: 64-bit register-immediate ALU, stream get/put, byte find.
// Assumes operands are presented with the issue strobe and that the stream
// partner runs on sys_clk, so its handshake needs no synchronisers.
`timescale 1ns/10ps
module long_imm_exec (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        issue_valid,
  input  wire logic [31:0] instr_word,
  input  wire logic [63:0] dest_value,
  input  wire logic [63:0] source_a_register,
  input  wire logic [63:0] source_b_register,
  output logic             busy,
  output logic             done,
  output logic [63:0]      result_value,
  output logic             result_write,
  output logic             carry_flag,
  output logic             stream_error_flag,
  output logic [3:0]       stream_channel_sel,
  input  wire logic [31:0] in_data,
  input  wire logic        incoming_data_valid,
  input  wire logic        incoming_ctrl_flag,
  output logic             in_read,
  output logic [31:0]      out_data,
  output logic             out_ctrl,
  output logic             out_write,
  input  wire logic        outgoing_channel_full,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  output logic             irq
);

  typedef struct packed {
    long_imm_exec_pkg::exec_state_t state;
    logic [31:0] instr;
    logic [63:0] dest;
    logic [63:0] src_a;
    logic [63:0] src_b;
    logic [63:0] result;
    logic        wr_en;
    logic        done;
    logic        carry;
    logic        serr;
    logic [2:0]  int_status;
    logic [2:0]  int_mask;
    logic [31:0] rdata;
  } exec_regs_t;

  exec_regs_t q_reg;
  exec_regs_t q_next;

  // Decoded view of the captured instruction
  logic [5:0]  opc;
  logic [4:0]  sub;
  logic        in_exec;
  logic        is_alu;
  logic        is_stream;
  logic        is_get;
  logic        is_put;
  logic        nonblk;
  logic        ctrl_op;
  logic        is_bfind;
  logic [63:0] simm;
  logic [3:0]  byte_eq;
  logic [63:0] bfind_val;

  assign opc       = q_reg.instr[long_imm_exec_pkg::OPC_HI:long_imm_exec_pkg::OPC_LO];
  assign sub       = q_reg.instr[long_imm_exec_pkg::SUB_HI:long_imm_exec_pkg::SUB_LO];
  assign in_exec   = (q_reg.state == long_imm_exec_pkg::ST_EXEC);
  assign is_alu    = (opc == long_imm_exec_pkg::OPC_LONG_IMM);
  assign is_stream = (opc == long_imm_exec_pkg::OPC_STREAM);
  assign is_put    = is_stream & q_reg.instr[long_imm_exec_pkg::PUT_BIT];
  assign is_get    = is_stream & ~q_reg.instr[long_imm_exec_pkg::PUT_BIT];
  assign nonblk    = q_reg.instr[long_imm_exec_pkg::NONBLK_BIT];
  assign ctrl_op   = q_reg.instr[long_imm_exec_pkg::CTRL_BIT];
  assign is_bfind  = (opc == long_imm_exec_pkg::OPC_OR_BF)
                   & (q_reg.instr[long_imm_exec_pkg::FUNC_HI:long_imm_exec_pkg::FUNC_LO]
                      == long_imm_exec_pkg::FUNC_BYTE_FIND);
  assign simm      = {{48{q_reg.instr[long_imm_exec_pkg::IMM_HI]}},
                      q_reg.instr[long_imm_exec_pkg::IMM_HI:long_imm_exec_pkg::IMM_LO]};

  // Byte 3 is the most significant byte of the low word
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_byte_cmp
      assign byte_eq[gi] = (q_reg.src_a[8*gi+7:8*gi] == q_reg.src_b[8*gi+7:8*gi]);
    end
  endgenerate

  // First match from the most significant byte wins
  always_comb begin
    if (byte_eq[3]) begin
      bfind_val = 64'h1;
    end else if (byte_eq[2]) begin
      bfind_val = 64'h2;
    end else if (byte_eq[1]) begin
      bfind_val = 64'h3;
    end else if (byte_eq[0]) begin
      bfind_val = 64'h4;
    end else begin
      bfind_val = 64'h0;
    end
  end

  // Stream handshakes; a nonblocking miss moves no word at all
  assign in_read   = in_exec & is_get & incoming_data_valid;
  assign out_write = in_exec & is_put & ~outgoing_channel_full;
  assign out_data  = q_reg.src_a[31:0];
  assign out_ctrl  = ctrl_op;
  assign stream_channel_sel = q_reg.instr[long_imm_exec_pkg::CHAN_HI:long_imm_exec_pkg::CHAN_LO];

  // Next-state logic: capture, execute, register bus
  always_comb begin
    logic [64:0] sum;
    logic [63:0] opnd;
    logic        cin;
    logic        finish;
    logic        ev_serr;
    logic        ev_miss;
    logic [2:0]  clr;
    sum     = 65'h0;
    opnd    = 64'h0;
    cin     = 1'b0;
    finish  = 1'b0;
    ev_serr = 1'b0;
    ev_miss = 1'b0;
    clr     = 3'h0;
    q_next       = q_reg;
    q_next.done  = 1'b0;
    q_next.wr_en = 1'b0;
    q_next.rdata = 32'h0;

    // Software writes come first so that hardware updates below override them
    if (reg_wr) begin
      case (reg_addr)
        long_imm_exec_pkg::ADDR_MSTATUS: begin
          q_next.carry = reg_wdata[long_imm_exec_pkg::MST_CARRY_BIT];
          q_next.serr  = reg_wdata[long_imm_exec_pkg::MST_SERR_BIT];
        end
        long_imm_exec_pkg::ADDR_INT_STAT: clr = reg_wdata[2:0];
        long_imm_exec_pkg::ADDR_INT_MASK: q_next.int_mask = reg_wdata[2:0];
        default: ;
      endcase
    end

    case (q_reg.state)
      long_imm_exec_pkg::ST_IDLE: begin
        if (issue_valid) begin
          q_next.state = long_imm_exec_pkg::ST_EXEC;
          q_next.instr = instr_word;
          q_next.dest  = dest_value;
          q_next.src_a = source_a_register;
          q_next.src_b = source_b_register;
        end
      end
      long_imm_exec_pkg::ST_EXEC: begin
        if (is_alu) begin
          finish = 1'b1;
          // Bit 0 of the sub-code reverses, bit 1 adds carry, bit 2 keeps carry
          opnd = sub[0] ? ~q_reg.dest : q_reg.dest;
          cin  = sub[1] & q_reg.carry;
          sum  = {1'b0, simm} + {1'b0, opnd} + {64'h0, cin};
          q_next.wr_en = 1'b1;
          case (sub)
            long_imm_exec_pkg::SUB_ADD, long_imm_exec_pkg::SUB_ADDK,
            long_imm_exec_pkg::SUB_ADDC, long_imm_exec_pkg::SUB_ADDKC,
            long_imm_exec_pkg::SUB_RSUB, long_imm_exec_pkg::SUB_RSUBK,
            long_imm_exec_pkg::SUB_RSUBC, long_imm_exec_pkg::SUB_RSUBKC: begin
              q_next.result = sum[63:0];
              if (!sub[2]) begin
                q_next.carry = sum[64];
              end
            end
            long_imm_exec_pkg::SUB_OR:   q_next.result = simm | q_reg.dest;
            long_imm_exec_pkg::SUB_AND:  q_next.result = simm & q_reg.dest;
            long_imm_exec_pkg::SUB_XOR:  q_next.result = simm ^ q_reg.dest;
            long_imm_exec_pkg::SUB_ANDN: q_next.result = simm & ~q_reg.dest;
            default: q_next.wr_en = 1'b0;
          endcase
        end else if (is_get) begin
          if (incoming_data_valid) begin
            finish = 1'b1;
            q_next.wr_en  = 1'b1;
            q_next.result = {32'h0, in_data};
            // Data get wants a data word, control get a control word
            if (incoming_ctrl_flag != ctrl_op) begin
              ev_serr = 1'b1;
            end
          end else if (nonblk) begin
            finish  = 1'b1;
            ev_miss = 1'b1;
          end
          if (nonblk) begin
            q_next.carry = ~incoming_data_valid;
          end
        end else if (is_put) begin
          // A blocking put simply waits here while the channel is full
          if (!outgoing_channel_full || nonblk) begin
            finish  = 1'b1;
            ev_miss = outgoing_channel_full;
          end
          if (nonblk) begin
            q_next.carry = outgoing_channel_full;
          end
        end else if (is_bfind) begin
          finish = 1'b1;
          q_next.wr_en  = 1'b1;
          q_next.result = bfind_val;
        end else begin
          // Opcodes outside this unit complete with no write-back
          finish = 1'b1;
        end
        if (finish) begin
          q_next.state = long_imm_exec_pkg::ST_IDLE;
          q_next.done  = 1'b1;
        end
      end
      default: q_next.state = long_imm_exec_pkg::ST_IDLE;
    endcase

    if (ev_serr) begin
      q_next.serr = 1'b1;
    end
    // Set wins over the write-one clear in the same cycle
    q_next.int_status = (q_reg.int_status & ~clr) | {ev_miss, ev_serr, finish};

    if (reg_rd) begin
      case (reg_addr)
        long_imm_exec_pkg::ADDR_MSTATUS:  q_next.rdata = {30'h0, q_reg.serr, q_reg.carry};
        long_imm_exec_pkg::ADDR_INT_STAT: q_next.rdata = {29'h0, q_reg.int_status};
        long_imm_exec_pkg::ADDR_INT_MASK: q_next.rdata = {29'h0, q_reg.int_mask};
        default:                          q_next.rdata = 32'h0;
      endcase
    end
  end

  // Single state register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q_reg            <= '0;
      q_reg.state      <= long_imm_exec_pkg::ST_IDLE;
      q_reg.carry      <= long_imm_exec_pkg::CARRY_RST;
      q_reg.serr       <= long_imm_exec_pkg::SERR_RST;
      q_reg.int_mask   <= long_imm_exec_pkg::INT_MASK_RST;
    end else begin
      q_reg <= q_next;
    end
  end

  assign busy              = in_exec;
  assign done              = q_reg.done;
  assign result_value      = q_reg.result;
  assign result_write      = q_reg.wr_en;
  assign carry_flag        = q_reg.carry;
  assign stream_error_flag = q_reg.serr;
  assign reg_rdata         = q_reg.rdata;
  // Level interrupt while any unmasked sticky bit is set
  assign irq               = |(q_reg.int_status & q_reg.int_mask);

  // Checks on decode and execute behaviour
  logic [63:0] chk_dest;
  logic [63:0] chk_imm;
  assign chk_dest = q_reg.dest;
  assign chk_imm  = simm;

  property p_add;
    @(posedge sys_clk) disable iff (rst)
      in_exec && is_alu && (sub == long_imm_exec_pkg::SUB_ADD)
      |=> result_write && done && (result_value == $past(chk_imm) + $past(chk_dest));
  endproperty
  a_add: assert property (p_add) else $error("add long immediate wrong");

  property p_addc;
    @(posedge sys_clk) disable iff (rst)
      in_exec && is_alu && (sub == long_imm_exec_pkg::SUB_ADDKC) && carry_flag
      |=> result_value == $past(chk_imm) + $past(chk_dest) + 64'h1;
  endproperty
  a_addc: assert property (p_addc) else $error("add with carry wrong");

  property p_rsub;
    @(posedge sys_clk) disable iff (rst)
      in_exec && is_alu && (sub == long_imm_exec_pkg::SUB_RSUBK)
      |=> result_value == $past(chk_imm) + ~$past(chk_dest);
  endproperty
  a_rsub: assert property (p_rsub) else $error("reverse subtract wrong");

  property p_andn;
    @(posedge sys_clk) disable iff (rst)
      in_exec && is_alu && (sub == long_imm_exec_pkg::SUB_ANDN)
      |=> result_value == ($past(chk_imm) & ~$past(chk_dest));
  endproperty
  a_andn: assert property (p_andn) else $error("and-not wrong");

  property p_xor;
    @(posedge sys_clk) disable iff (rst)
      in_exec && is_alu && (sub == long_imm_exec_pkg::SUB_XOR)
      |=> result_value == ($past(chk_imm) ^ $past(chk_dest));
  endproperty
  a_xor: assert property (p_xor) else $error("xor wrong");

  property p_get_block;
    @(posedge sys_clk) disable iff (rst)
      in_exec && is_get && !nonblk && !incoming_data_valid
      |-> !in_read ##1 (busy && !done);
  endproperty
  a_get_block: assert property (p_get_block) else $error("blocking get did not stall");

  property p_serr;
    @(posedge sys_clk) disable iff (rst)
      in_exec && is_get && !ctrl_op && incoming_data_valid && incoming_ctrl_flag
      |=> stream_error_flag && result_write;
  endproperty
  a_serr: assert property (p_serr) else $error("stream error not raised");

  property p_nb_get;
    @(posedge sys_clk) disable iff (rst)
      in_exec && is_get && nonblk
      |=> done && (carry_flag == !$past(incoming_data_valid));
  endproperty
  a_nb_get: assert property (p_nb_get) else $error("nonblocking get carry wrong");

  property p_put_full;
    @(posedge sys_clk) disable iff (rst)
      in_exec && is_put && !nonblk && outgoing_channel_full
      |-> !out_write ##1 busy;
  endproperty
  a_put_full: assert property (p_put_full) else $error("put sent into full channel");

  property p_nb_put;
    @(posedge sys_clk) disable iff (rst)
      in_exec && is_put && nonblk
      |=> done && (carry_flag == $past(outgoing_channel_full));
  endproperty
  a_nb_put: assert property (p_nb_put) else $error("nonblocking put carry wrong");

  property p_bfind;
    @(posedge sys_clk) disable iff (rst)
      in_exec && is_bfind && byte_eq[3]
      |=> result_write && (result_value == 64'h1);
  endproperty
  a_bfind: assert property (p_bfind) else $error("byte find priority wrong");

  property p_keep;
    @(posedge sys_clk) disable iff (rst)
      in_exec && is_alu && sub[2] && !sub[4] && !reg_wr
      |=> $stable(carry_flag);
  endproperty
  a_keep: assert property (p_keep) else $error("keep form changed carry");

endmodule : long_imm_exec

//--- verification/stream_partner.sv
// Far-side stream logic: feeds words to the core and collects what it pushes.
// Assumes the core's in_read and out_write are sampled on the same sys_clk edge.
`timescale 1ns/10ps
module stream_partner (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        stall_out,
  input  wire logic        in_read,
  input  wire logic [31:0] out_data,
  input  wire logic        out_ctrl,
  input  wire logic        out_write,
  output logic [31:0]      in_data,
  output logic             incoming_data_valid,
  output logic             incoming_ctrl_flag,
  output logic             outgoing_channel_full
);
  logic [32:0] tx_q[$];
  logic [32:0] rx_q[$];
  logic [31:0] junk_reg;

  // Outputs move only just after an edge; an idle data line keeps changing
  // so a core that reads it without a valid word cannot pass by luck
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      junk_reg              <= 32'hA5C3_3C5A;
      in_data               <= 32'h0;
      incoming_data_valid   <= 1'b0;
      incoming_ctrl_flag    <= 1'b0;
      outgoing_channel_full <= 1'b0;
    end else begin
      if (in_read === 1'b1 && tx_q.size() != 0) begin
        tx_q.delete(0);
      end
      if (out_write === 1'b1) begin
        rx_q.push_back({out_ctrl, out_data});
      end
      junk_reg              <= {junk_reg[30:0], junk_reg[31] ^ junk_reg[21]} ^ 32'h1;
      incoming_data_valid   <= (tx_q.size() != 0);
      in_data               <= (tx_q.size() != 0) ? tx_q[0][31:0] : ~junk_reg;
      incoming_ctrl_flag    <= (tx_q.size() != 0) ? tx_q[0][32] : junk_reg[0];
      outgoing_channel_full <= stall_out;
    end
  end
endmodule : stream_partner

//--- verification/tb_long_imm_exec.sv
// Self-checking bench for the long-immediate execute unit.
// Assumes one 100 MHz clock shared by core, register port and stream partner.
`timescale 1ns/10ps
module tb_long_imm_exec;
  typedef struct packed {
    logic        wr;
    logic [63:0] val;
    logic        c;
    logic        s;
    logic [3:0]  sel;
  } exp_t;
  logic        sys_clk, rst, issue_valid, busy, done, result_write, carry_flag;
  logic        stream_error_flag, incoming_data_valid, incoming_ctrl_flag, in_read;
  logic        out_ctrl, out_write, outgoing_channel_full, reg_wr, reg_rd, irq;
  logic        stall_out, rd_seen, exp_c, exp_s;
  logic [31:0] instr_word, in_data, out_data, reg_wdata, reg_rdata, w;
  logic [63:0] dest_value, source_a_register, source_b_register, result_value, a, b;
  logic [64:0] r;
  logic [15:0] imm;
  logic [4:0]  subs [12];
  logic [3:0]  stream_channel_sel;
  logic [7:0]  reg_addr;
  exp_t        exp_q[$];
  logic [31:0] rd_q[$];
  exp_t        e;
  int          num_errors, checked, seed, k;

  long_imm_exec long_imm_exec_inst (.sys_clk(sys_clk), .rst(rst), .issue_valid(issue_valid),
    .instr_word(instr_word), .dest_value(dest_value), .source_a_register(source_a_register),
    .source_b_register(source_b_register), .busy(busy), .done(done),
    .result_value(result_value), .result_write(result_write), .carry_flag(carry_flag),
    .stream_error_flag(stream_error_flag), .stream_channel_sel(stream_channel_sel),
    .in_data(in_data), .incoming_data_valid(incoming_data_valid),
    .incoming_ctrl_flag(incoming_ctrl_flag), .in_read(in_read), .out_data(out_data),
    .out_ctrl(out_ctrl), .out_write(out_write), .outgoing_channel_full(outgoing_channel_full),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq));
  stream_partner stream_partner_inst (.sys_clk(sys_clk), .rst(rst), .stall_out(stall_out),
    .in_read(in_read), .out_data(out_data), .out_ctrl(out_ctrl), .out_write(out_write),
    .in_data(in_data), .incoming_data_valid(incoming_data_valid),
    .incoming_ctrl_flag(incoming_ctrl_flag), .outgoing_channel_full(outgoing_channel_full));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic report_and_stop();
    if (num_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string name, input logic [63:0] x, input logic [63:0] g);
    checked++;
    if (g !== x) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, x, g);
    end
  endtask : chk

  // Reference arithmetic: returns {carry, result}; keep forms hold the carry
  function automatic logic [64:0] alu(input logic [4:0] s, input logic [15:0] i,
                                      input logic [63:0] d, input logic c);
    logic [64:0] x;
    logic [64:0] q;
    x = {1'b0, {48{i[15]}}, i};
    case (s[4:0])
      5'h00, 5'h04: q = x + {1'b0, d};
      5'h01, 5'h05: q = x + {1'b0, ~d};
      5'h02, 5'h06: q = x + {1'b0, d} + 65'(c);
      5'h03, 5'h07: q = x + {1'b0, ~d} + 65'(c);
      5'h10:        q = {c, x[63:0] | d};
      5'h11:        q = {c, x[63:0] & d};
      5'h12:        q = {c, x[63:0] ^ d};
      default:      q = {c, x[63:0] & ~d};
    endcase
    if (s[4] == 1'b0 && s[2] == 1'b1) q[64] = c;
    return q;
  endfunction : alu

  function automatic logic [31:0] strm(input logic p, n, c, input logic [3:0] ch);
    return {long_imm_exec_pkg::OPC_STREAM, 5'h3, 5'h4, p, n, c, 9'h0, ch};
  endfunction : strm

  task automatic wreg(input logic [7:0] ad, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= ad;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [7:0] ad, input logic [31:0] x);
    rd_q.push_back(x);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= ad;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
  endtask : rreg

  task automatic wirq(input logic [7:0] ad, input logic [31:0] d, input logic x);
    wreg(ad, d);
    @(negedge sys_clk);
    chk("irq", 64'(x), 64'(irq));
  endtask : wirq

  task automatic issue(input logic [31:0] ins, input logic [63:0] d, sa, sb,
                       input logic wr, input logic [63:0] v);
    int i;
    exp_q.push_back('{wr, v, exp_c, exp_s, ins[3:0]});
    @(posedge sys_clk);
    issue_valid       <= 1'b1;
    instr_word        <= ins;
    dest_value        <= d;
    source_a_register <= sa;
    source_b_register <= sb;
    @(posedge sys_clk);
    issue_valid       <= 1'b0;
    i = 0;
    do begin
      @(negedge sys_clk);
      i++;
    end while (done !== 1'b1 && i < 300);
    if (i >= 300) chk("done_wait", 64'h1, 64'h0);
  endtask : issue

  task automatic tx(input logic [31:0] d, input logic c, input logic nb);
    stream_partner_inst.tx_q.push_back({c, d});
    repeat (2) @(posedge sys_clk);
    if (nb) exp_c = 1'b0;
  endtask : tx

  // Watcher: every completion and every register read is matched to its note
  always @(posedge sys_clk) rd_seen <= reg_rd;
  always @(negedge sys_clk) begin
    if (done === 1'b1) begin
      if (exp_q.size() == 0) chk("done_extra", 64'h0, 64'h1);
      else begin
        e = exp_q.pop_front();
        chk("result_write", 64'(e.wr), 64'(result_write));
        if (e.wr) chk("result_value", e.val, result_value);
        chk("carry_flag", 64'(e.c), 64'(carry_flag));
        chk("stream_error_flag", 64'(e.s), 64'(stream_error_flag));
        chk("stream_channel_sel", 64'(e.sel), 64'(stream_channel_sel));
      end
    end
    if (rd_seen === 1'b1) chk("reg_rdata", 64'(rd_q.pop_front()), 64'(reg_rdata));
  end

  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    {rst, issue_valid, reg_wr, reg_rd, stall_out, exp_c, exp_s} = 7'h40;
    {instr_word, reg_wdata, reg_addr} = 72'h0;
    {dest_value, source_a_register, source_b_register} = 192'h0;
    num_errors = 0;
    checked = 0;
    seed = 52227;
    subs = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
             5'h10, 5'h11, 5'h12, 5'h13};
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    rreg(long_imm_exec_pkg::ADDR_MSTATUS, 32'h0);
    rreg(long_imm_exec_pkg::ADDR_INT_MASK, 32'h0);
    rreg(8'h0C, 32'h0);
    // Every long-immediate code, random operands and all-ones register with immediate 1, both carries
    for (k = 0; k < 36; k++) begin
      imm = (k >= 24) ? 16'h0001 : 16'($random(seed));
      a   = (k >= 24) ? 64'hFFFF_FFFF_FFFF_FFFF : {$random(seed), $random(seed)};
      exp_c = k[0] ^ k[3];
      exp_s = 1'b0;
      wreg(long_imm_exec_pkg::ADDR_MSTATUS, {31'h0, exp_c});
      r = alu(subs[k % 12], imm, a, exp_c);
      exp_c = r[64];
      issue({long_imm_exec_pkg::OPC_LONG_IMM, 5'h7, subs[k % 12], imm}, a,
            {$random(seed), $random(seed)}, a, 1'b1, r[63:0]);
    end
    issue({long_imm_exec_pkg::OPC_LONG_IMM, 5'h1, 5'h08, 16'h1234}, a, a, a, 1'b0, 64'h0);
    // Data and control gets with matching and mismatching word kinds
    for (k = 0; k < 4; k++) begin
      wreg(long_imm_exec_pkg::ADDR_MSTATUS, 32'h1);
      exp_c = 1'b1;
      w = $random(seed);
      tx(w, k[0], 1'b0);
      exp_s = k[0] ^ k[1];
      issue(strm(1'b0, 1'b0, k[1], 4'(k + 2)), a, a, a, 1'b1, {32'h0, w});
    end
    tx(32'h0BAD_F00D, 1'b0, 1'b1);
    issue(strm(1'b0, 1'b1, 1'b0, 4'hF), a, a, a, 1'b1, 64'h0BAD_F00D);
    exp_c = 1'b1;
    issue(strm(1'b0, 1'b1, 1'b1, 4'h9), a, a, a, 1'b0, 64'h0);
    // Blocking get stalls until the partner finally offers a word
    fork
      issue(strm(1'b0, 1'b0, 1'b0, 4'h1), a, a, a, 1'b1, 64'h0000_0000_7777_1111);
      begin
        repeat (6) @(negedge sys_clk);
        chk("busy_get", 64'h1, 64'(busy));
        stream_partner_inst.tx_q.push_back({1'b0, 32'h7777_1111});
      end
    join
    // Puts: non-blocking both kinds, refused when full, blocking until space
    for (k = 0; k < 2; k++) begin
      b = {$random(seed), $random(seed)};
      exp_c = 1'b0;
      issue(strm(1'b1, 1'b1, k[0], 4'h3), a, b, a, 1'b0, 64'h0);
      chk("put_word", {k[0], b[31:0]}, 64'(stream_partner_inst.rx_q.pop_front()));
    end
    @(posedge sys_clk);
    stall_out <= 1'b1;
    repeat (2) @(posedge sys_clk);
    exp_c = 1'b1;
    issue(strm(1'b1, 1'b1, 1'b0, 4'h4), a, b, a, 1'b0, 64'h0);
    chk("put_refused", 64'h0, 64'(stream_partner_inst.rx_q.size()));
    fork
      issue(strm(1'b1, 1'b0, 1'b1, 4'h8), a, 64'h0000_0000_1357_2468, a, 1'b0, 64'h0);
      begin
        repeat (6) @(negedge sys_clk);
        chk("busy_put", 64'h1, 64'(busy));
        @(posedge sys_clk);
        stall_out <= 1'b0;
      end
    join
    chk("put_late", 64'h1_1357_2468, 64'(stream_partner_inst.rx_q.pop_front()));
    // Byte find: first match from the top byte wins, none gives zero
    for (k = 0; k < 5; k++) begin
      a = {$random(seed), $random(seed)};
      b = ~a;
      if (k > 0) b[31 - 8 * (k - 1) -: 8] = a[31 - 8 * (k - 1) -: 8];
      if (k > 0) b[7:0] = a[7:0];
      issue({6'h20, 5'h1, 5'h2, 5'h3, long_imm_exec_pkg::FUNC_BYTE_FIND}, a, a, b,
            1'b1, 64'(k));
    end
    // Interrupt: sticky events, masking and write-one-to-clear
    wreg(long_imm_exec_pkg::ADDR_INT_STAT, 32'h7);
    rreg(long_imm_exec_pkg::ADDR_INT_STAT, 32'h0);
    exp_c = 1'b1;
    issue(strm(1'b0, 1'b1, 1'b0, 4'h2), a, a, a, 1'b0, 64'h0);
    rreg(long_imm_exec_pkg::ADDR_INT_STAT, 32'h5);
    wirq(long_imm_exec_pkg::ADDR_INT_MASK, 32'h2, 1'b0);
    wirq(long_imm_exec_pkg::ADDR_INT_MASK, 32'h4, 1'b1);
    wirq(long_imm_exec_pkg::ADDR_INT_STAT, 32'h4, 1'b0);
    rreg(long_imm_exec_pkg::ADDR_INT_STAT, 32'h1);
    wirq(long_imm_exec_pkg::ADDR_INT_MASK, 32'h1, 1'b1);
    wirq(long_imm_exec_pkg::ADDR_INT_STAT, 32'h1, 1'b0);
    rreg(long_imm_exec_pkg::ADDR_INT_MASK, 32'h1);
    repeat (3) @(posedge sys_clk);
    report_and_stop();
  end
endmodule : tb_long_imm_exec
